/* File: verilog/srpc_params.svh */
`ifndef SRPC_PARAMS_SVH
`define SRPC_PARAMS_SVH

// Register offsets inside the clock address space.
`define SRPC_ADDR_STATUS 6'h30
`define SRPC_ADDR_CLKCTL 6'h31
`define SRPC_ADDR_IRQCTL 6'h32

// Clock setup register fields.
`define SRPC_CC_RUN 7
`define SRPC_CC_LINE 6
`define SRPC_CC_OSC_HI 5
`define SRPC_CC_OSC_LO 4
`define SRPC_CC_50HZ 3
`define SRPC_CC_SQ_HI 2
`define SRPC_CC_SQ_LO 0

// Interrupt setup register fields.
`define SRPC_IC_WD 7
`define SRPC_IC_PD 6
`define SRPC_IC_PS 5
`define SRPC_IC_AL 4
`define SRPC_IC_RATE_HI 3
`define SRPC_IC_RATE_LO 0

// Reset values.
`define SRPC_CTL_RST 8'h00
`define SRPC_POR_WAIT_RST 2'h3

// Pin positions inside the synchroniser vector.
`define SRPC_PIN_CS 0
`define SRPC_PIN_SCK 1
`define SRPC_PIN_MOSI 2
`define SRPC_PIN_XTAL 3
`define SRPC_PIN_LINE 4
`define SRPC_PIN_SYSTEM_VOLTAGE_SENSE 5
`define SRPC_PIN_FAIL 6
`define SRPC_PIN_TEST 7

// Crystal edges per 64 Hz tick, as a power of two.
`define SRPC_SH_4M 5'h10
`define SRPC_SH_2M 5'h0F
`define SRPC_SH_1M 5'h0E
`define SRPC_SH_32K 5'h09

// Line cycles per second.
`define SRPC_LINE_50 6'h32
`define SRPC_LINE_60 6'h3C

// Watchdog: reset time of 15.6 ms min, one 64 Hz tick is 15625 us.
`define SRPC_TICK64_US 15625
`define SRPC_WD_MIN_US 15600
`define SRPC_WD_TICKS (2'((`SRPC_WD_MIN_US + `SRPC_TICK64_US - 1) / `SRPC_TICK64_US) + 2'h1)

`endif

/* File: verilog/srpc_pkg.sv */
package srpc_pkg;

	typedef enum logic [1:0] {
		SRPC_IDLE = 2'b00,
		SRPC_ADDR = 2'b01,
		SRPC_WRITE = 2'b10,
		SRPC_READ = 2'b11
	} srpc_spi_t;

	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic [1:0] por_wait;
		logic batt_mode;
		logic [7:0] clk_ctl;
		logic [7:0] irq_ctl;
		logic wd_flt;
		logic cold;
		logic ps_flg;
		logic al_flg;
		logic pe_flg;
		logic irq_pend;
		logic ps_armed;
		logic [21:0] xdiv;
		logic [5:0] chain;
		logic [5:0] linecnt;
		logic [1:0] wd_cnt;
		logic wd_hrst;
		logic sck_seen;
		logic sq;
		logic supply_en;
		logic hrst_oe;
		logic irq_oe;
		logic sec_tick;
		srpc_spi_t spi;
		logic cpol;
		logic [2:0] bitcnt;
		logic [7:0] shreg;
		logic [5:0] addr;
		logic rd_load;
		logic miso;
		logic miso_oe;
		logic [13:0] pend;
		logic pend_v;
		logic [13:0] ent0;
		logic [13:0] ent1;
		logic [1:0] cnt;
		logic wr_valid;
	} srpc_state_t;

endpackage

/* File: verilog/srpc_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "srpc_params.svh"

module srpc_core
	import srpc_pkg::*;
(
	input wire logic mclk, // 40 MHz system clock.
	input wire logic rst_n, // Power-on reset, synchronous, active low.
	input wire logic chip_select_in, // Serial chip select pin, active high.
	input wire logic sck_in, // Serial clock pin, either idle polarity.
	input wire logic mosi_in, // Serial data in pin.
	output logic miso_out, // Serial data out value.
	output logic miso_oe, // Serial data out enable, high while driving.
	input wire logic xtal_in, // Crystal or external clock level.
	input wire logic line_in, // Line frequency level.
	input wire logic system_voltage_sense, // System supply above battery level.
	input wire logic power_fail_in, // Line threshold detector reports lost AC.
	input wire logic test_mode_in, // Test mode indication.
	input wire logic alarm_match_in, // One-cycle pulse: time equals alarm.
	input wire logic minute_tick_in, // One-cycle pulse from minute counter.
	input wire logic hour_tick_in, // One-cycle pulse from hour counter.
	input wire logic day_tick_in, // One-cycle pulse from day counter.
	output logic second_tick_out, // One-cycle one-second update pulse.
	output logic square_wave_out, // Square-wave clock output.
	output logic supply_enable_out, // Power supply enable.
	output logic host_reset_out, // Host reset open-drain value, always low.
	output logic host_reset_oe, // Host reset pulled low while high.
	output logic irq_out, // Interrupt open-drain value, always low.
	output logic irq_oe, // Interrupt pulled low while high.
	output logic battery_mode_out, // Latched battery-backup mode.
	output logic [5:0] ext_rd_addr, // Address of external read.
	input wire logic [7:0] ext_rd_data, // External read data, same cycle.
	output logic ext_wr_valid, // Write buffer head valid.
	output logic [5:0] ext_wr_addr, // Write buffer head address.
	output logic [7:0] ext_wr_data, // Write buffer head data.
	input wire logic ext_wr_ready // Downstream takes the head.
);

	localparam srpc_state_t SRPC_RESET = '{
		por_wait: `SRPC_POR_WAIT_RST,
		cold: 1'b1,
		clk_ctl: `SRPC_CTL_RST,
		irq_ctl: `SRPC_CTL_RST,
		spi: SRPC_IDLE,
		default: '0
	};

	srpc_state_t state_reg;
	srpc_state_t state_next;

	// Crystal edges per 64 Hz tick for the selected oscillator.
	function automatic logic [4:0] osc_shift(input logic [1:0] sel);
		case (sel)
			2'h0: osc_shift = `SRPC_SH_4M;
			2'h1: osc_shift = `SRPC_SH_2M;
			2'h2: osc_shift = `SRPC_SH_1M;
			default: osc_shift = `SRPC_SH_32K;
		endcase
	endfunction

	// True when the low bits of a counter are all zero.
	function automatic logic low_zero(input logic [21:0] v, input logic [4:0] bits);
		low_zero = (v & ((22'h1 << bits) - 22'h1)) == 22'h0;
	endfunction

	// Burst address step, wrapping inside RAM or clock space.
	function automatic logic [5:0] next_addr(input logic [5:0] a);
		next_addr = {a[5], 5'(a[4:0] + 5'h01)};
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// Whole next-state computation.
	always_comb begin
		logic pd;
		logic line_base;
		logic [4:0] sh;
		logic xr;
		logic lr;
		logic tick64;
		logic x1hz;
		logic l1hz;
		logic l2hz;
		logic [5:0] lmax;
		logic per_tick;
		logic [3:0] rate;
		logic cs_rise;
		logic cs_fall;
		logic sck_chg;
		logic lead;
		logic trail;
		logic [7:0] byte_in;
		logic [7:0] status;
		logic st_clr;
		logic pd_write;
		logic ps_ev;
		logic al_ev;
		logic pe_ev;
		logic pop;
		logic [13:0] e0;
		logic [13:0] e1;
		logic [1:0] c;
		pd = state_reg.irq_ctl[`SRPC_IC_PD];
		line_base = state_reg.clk_ctl[`SRPC_CC_LINE];
		sh = osc_shift(state_reg.clk_ctl[`SRPC_CC_OSC_HI:`SRPC_CC_OSC_LO]);
		xr = 1'b0;
		lr = 1'b0;
		tick64 = 1'b0;
		x1hz = 1'b0;
		l1hz = 1'b0;
		l2hz = 1'b0;
		lmax = `SRPC_LINE_60;
		per_tick = 1'b0;
		rate = state_reg.irq_ctl[`SRPC_IC_RATE_HI:`SRPC_IC_RATE_LO];
		cs_rise = 1'b0;
		cs_fall = 1'b0;
		sck_chg = 1'b0;
		lead = 1'b0;
		trail = 1'b0;
		byte_in = 8'h00;
		st_clr = 1'b0;
		pd_write = 1'b0;
		pop = 1'b0;
		e0 = state_reg.ent0;
		e1 = state_reg.ent1;
		c = state_reg.cnt;
		state_next = state_reg;

		// Every pin passes two flip-flops; only the second stage and the history are read.
		state_next.sync1 = {test_mode_in, power_fail_in, system_voltage_sense, line_in,
			xtal_in, mosi_in, sck_in, chip_select_in};
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;

		// Crystal prescaler runs always; the 64 Hz to 1 Hz chain stops when run is low.
		xr = state_reg.sync2[`SRPC_PIN_XTAL] & ~state_reg.prev[`SRPC_PIN_XTAL];
		if (xr) begin
			state_next.xdiv = state_reg.xdiv + 22'h1;
		end
		tick64 = xr && low_zero(state_next.xdiv, sh);
		if (!state_reg.clk_ctl[`SRPC_CC_RUN]) begin
			state_next.chain = 6'h00;
		end else if (tick64) begin
			state_next.chain = state_reg.chain + 6'h01;
		end
		x1hz = tick64 && state_reg.clk_ctl[`SRPC_CC_RUN] && state_next.chain == 6'h00;

		// Line prescaler; power sense disconnects its input.
		lr = state_reg.sync2[`SRPC_PIN_LINE] & ~state_reg.prev[`SRPC_PIN_LINE]
			& ~state_reg.irq_ctl[`SRPC_IC_PS];
		lmax = state_reg.clk_ctl[`SRPC_CC_50HZ] ? `SRPC_LINE_50 : `SRPC_LINE_60;
		if (!state_reg.clk_ctl[`SRPC_CC_RUN]) begin
			state_next.linecnt = 6'h00;
		end else if (lr) begin
			state_next.linecnt = (state_reg.linecnt == lmax - 6'h01) ? 6'h00 :
				state_reg.linecnt + 6'h01;
		end
		l1hz = lr && state_reg.clk_ctl[`SRPC_CC_RUN] && state_next.linecnt == 6'h00;
		l2hz = l1hz || (lr && state_reg.clk_ctl[`SRPC_CC_RUN]
			&& state_next.linecnt == {1'b0, lmax[5:1]});
		state_next.sec_tick = line_base ? l1hz : x1hz;

		// Periodic source; crystal-only rates stay silent on the line base.
		case (rate)
			4'h0: per_tick = 1'b0;
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5: per_tick = !line_base
				&& xr && low_zero(state_next.xdiv, 5'(sh + {1'b0, rate} - 5'h06));
			4'h6: per_tick = line_base ? lr : tick64;
			4'h7, 4'h8, 4'h9, 4'hA: per_tick = !line_base
				&& tick64 && low_zero({16'h0000, state_next.chain}, 5'({1'b0, rate} - 5'h06));
			4'hB: per_tick = line_base ? l2hz : (tick64 && state_next.chain[4:0] == 5'h00);
			4'hC: per_tick = line_base ? l1hz : x1hz;
			4'hD: per_tick = minute_tick_in;
			4'hE: per_tick = hour_tick_in;
			default: per_tick = day_tick_in;
		endcase

		// Status byte as software sees it.
		status = {1'b0, state_reg.wd_flt, state_reg.sync2[`SRPC_PIN_TEST], state_reg.cold,
			state_reg.ps_flg | state_reg.al_flg | state_reg.pe_flg,
			state_reg.ps_flg, state_reg.al_flg, state_reg.pe_flg};

		////////////////////////////////////////////////////////////////////////////////

		// Serial slave; deselect or power-down holds it in reset with the output floating.
		cs_rise = state_reg.sync2[`SRPC_PIN_CS] & ~state_reg.prev[`SRPC_PIN_CS];
		cs_fall = ~state_reg.sync2[`SRPC_PIN_CS] & state_reg.prev[`SRPC_PIN_CS];
		sck_chg = state_reg.sync2[`SRPC_PIN_SCK] ^ state_reg.prev[`SRPC_PIN_SCK];
		lead = sck_chg && state_reg.prev[`SRPC_PIN_SCK] == state_reg.cpol;
		trail = sck_chg && state_reg.prev[`SRPC_PIN_SCK] != state_reg.cpol;
		byte_in = {state_reg.shreg[6:0], state_reg.sync2[`SRPC_PIN_MOSI]};
		if (!state_reg.sync2[`SRPC_PIN_CS] || pd) begin
			state_next.spi = SRPC_IDLE;
			state_next.miso_oe = 1'b0;
			state_next.rd_load = 1'b0;
			state_next.bitcnt = 3'h0;
		end else if (cs_rise) begin
			// Idle clock level is sampled as select goes true.
			state_next.spi = SRPC_ADDR;
			state_next.cpol = state_reg.sync2[`SRPC_PIN_SCK];
			state_next.bitcnt = 3'h0;
			state_next.sck_seen = 1'b0;
			state_next.miso_oe = 1'b0;
		end else begin
			if (sck_chg) begin
				state_next.sck_seen = 1'b1;
			end
			// A read byte is fetched one cycle after its address is known.
			if (state_reg.rd_load) begin
				state_next.rd_load = 1'b0;
				state_next.miso_oe = 1'b1;
				if (state_reg.addr == `SRPC_ADDR_STATUS) begin
					state_next.shreg = status;
					st_clr = 1'b1;
				end else if (state_reg.addr == `SRPC_ADDR_CLKCTL) begin
					state_next.shreg = state_reg.clk_ctl;
				end else if (state_reg.addr == `SRPC_ADDR_IRQCTL) begin
					state_next.shreg = state_reg.irq_ctl;
				end else begin
					state_next.shreg = ext_rd_data;
				end
			end else if (lead && state_reg.spi == SRPC_READ) begin
				state_next.miso = state_reg.shreg[7];
				state_next.shreg = {state_reg.shreg[6:0], 1'b0};
			end
			if (trail) begin
				state_next.bitcnt = state_reg.bitcnt + 3'h1;
				case (state_reg.spi)
					SRPC_ADDR: begin
						state_next.shreg = byte_in;
						if (state_reg.bitcnt == 3'h7) begin
							state_next.addr = {byte_in[5], byte_in[4:0]};
							state_next.spi = byte_in[7] ? SRPC_WRITE : SRPC_READ;
							state_next.rd_load = ~byte_in[7];
						end
					end
					SRPC_WRITE: begin
						state_next.shreg = byte_in;
						if (state_reg.bitcnt == 3'h7) begin
							state_next.addr = next_addr(state_reg.addr);
							if (state_reg.addr == `SRPC_ADDR_CLKCTL) begin
								state_next.clk_ctl = byte_in;
							end else if (state_reg.addr == `SRPC_ADDR_IRQCTL) begin
								state_next.irq_ctl = byte_in;
								pd_write = byte_in[`SRPC_IC_PD];
								// Sense rearms only on a zero-to-one write.
								if (!byte_in[`SRPC_IC_PS]) begin
									state_next.ps_armed = 1'b0;
								end else if (!state_reg.irq_ctl[`SRPC_IC_PS]) begin
									state_next.ps_armed = 1'b1;
								end
							end else if (state_reg.addr != `SRPC_ADDR_STATUS) begin
								state_next.pend = {state_reg.addr, byte_in};
								state_next.pend_v = 1'b1;
							end
						end
					end
					SRPC_READ: begin
						if (state_reg.bitcnt == 3'h7) begin
							state_next.addr = next_addr(state_reg.addr);
							state_next.rd_load = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end

		////////////////////////////////////////////////////////////////////////////////

		// Two-entry write buffer: pop the head first, then accept the held byte if room.
		// A byte held while both entries are full waits; the next byte overwrites it only
		// if the drain stalls for a whole serial byte time.
		pop = ext_wr_ready && state_reg.cnt != 2'h0;
		if (pop) begin
			e0 = state_reg.ent1;
			c = state_reg.cnt - 2'h1;
		end
		if (state_next.pend_v && c != 2'h2) begin
			if (c == 2'h0) begin
				e0 = state_next.pend;
			end else begin
				e1 = state_next.pend;
			end
			c = c + 2'h1;
			state_next.pend_v = 1'b0;
		end
		state_next.ent0 = e0;
		state_next.ent1 = e1;
		state_next.cnt = c;
		state_next.wr_valid = c != 2'h0;

		// Status read clears first so an event in the same cycle still sets its flag.
		if (st_clr) begin
			state_next.wd_flt = 1'b0;
			state_next.cold = 1'b0;
			state_next.al_flg = 1'b0;
			state_next.pe_flg = 1'b0;
			state_next.irq_pend = 1'b0;
		end
		if (pd_write) begin
			state_next.supply_en = 1'b0;
		end

		// Interrupt sources.
		pe_ev = per_tick && rate != 4'h0;
		al_ev = alarm_match_in && state_reg.irq_ctl[`SRPC_IC_AL];
		ps_ev = state_reg.sync2[`SRPC_PIN_FAIL] && !state_reg.prev[`SRPC_PIN_FAIL]
			&& state_reg.irq_ctl[`SRPC_IC_PS] && state_reg.ps_armed;
		if (pe_ev) begin
			state_next.pe_flg = 1'b1;
		end
		if (al_ev) begin
			state_next.al_flg = 1'b1;
		end
		if (ps_ev) begin
			state_next.ps_flg = 1'b1;
			state_next.ps_armed = 1'b0;
		end
		if (pe_ev || al_ev || ps_ev) begin
			state_next.irq_pend = 1'b1;
			state_next.irq_ctl[`SRPC_IC_PD] = 1'b0;
			state_next.supply_en = 1'b1;
		end

		// Supply recovery ends power-down in either supply mode.
		if (state_reg.sync2[`SRPC_PIN_SYSTEM_VOLTAGE_SENSE] && !state_reg.prev[`SRPC_PIN_SYSTEM_VOLTAGE_SENSE]) begin
			state_next.supply_en = 1'b1;
			state_next.irq_ctl[`SRPC_IC_PD] = 1'b0;
		end

		// The supply level is caught once the synchronisers hold a real sample.
		if (state_reg.por_wait != 2'h0) begin
			state_next.por_wait = state_reg.por_wait - 2'h1;
			if (state_reg.por_wait == 2'h1) begin
				state_next.batt_mode = ~state_reg.sync2[`SRPC_PIN_SYSTEM_VOLTAGE_SENSE];
				state_next.supply_en = state_reg.sync2[`SRPC_PIN_SYSTEM_VOLTAGE_SENSE];
			end
		end

		// Watchdog counts 64 Hz ticks; a select toggle with no clock edge services it.
		if (tick64 && state_reg.wd_hrst) begin
			state_next.wd_hrst = 1'b0;
		end
		if (!state_reg.irq_ctl[`SRPC_IC_WD]) begin
			state_next.wd_cnt = 2'h0;
		end else if (cs_fall && !state_reg.sck_seen) begin
			state_next.wd_cnt = 2'h0;
		end else if (tick64) begin
			if (state_reg.wd_cnt + 2'h1 == `SRPC_WD_TICKS) begin
				state_next.wd_cnt = 2'h0;
				state_next.wd_flt = 1'b1;
				state_next.wd_hrst = 1'b1;
			end else begin
				state_next.wd_cnt = state_reg.wd_cnt + 2'h1;
			end
		end

		// Pin drivers follow the final power-down state.
		state_next.hrst_oe = state_next.irq_ctl[`SRPC_IC_PD] | state_next.wd_hrst;
		state_next.irq_oe = state_next.irq_pend;
		case (state_reg.clk_ctl[`SRPC_CC_SQ_HI:`SRPC_CC_SQ_LO])
			3'h0: state_next.sq = state_reg.sync2[`SRPC_PIN_XTAL];
			3'h1: state_next.sq = state_reg.xdiv[0];
			3'h2: state_next.sq = state_reg.xdiv[1];
			3'h3: state_next.sq = state_reg.xdiv[2];
			3'h4: state_next.sq = 1'b0;
			3'h5: state_next.sq = state_reg.chain[5];
			3'h6: state_next.sq = state_reg.chain[4];
			default: state_next.sq = line_base ? state_reg.sync2[`SRPC_PIN_LINE] :
				state_reg.xdiv[5'(sh - 5'h01)];
		endcase
		if (state_next.irq_ctl[`SRPC_IC_PD]) begin
			state_next.sq = 1'b0;
		end
	end

	// Power-on reset loads constants only; everything else is registered here.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= SRPC_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Outputs come straight from the state register.
	assign miso_out = state_reg.miso;
	assign miso_oe = state_reg.miso_oe;
	assign second_tick_out = state_reg.sec_tick;
	assign square_wave_out = state_reg.sq;
	assign supply_enable_out = state_reg.supply_en;
	assign host_reset_out = state_reg.sck_seen & 1'b0;
	assign host_reset_oe = state_reg.hrst_oe;
	assign irq_out = state_reg.irq_pend & 1'b0;
	assign irq_oe = state_reg.irq_oe;
	assign battery_mode_out = state_reg.batt_mode;
	assign ext_rd_addr = state_reg.addr;
	assign ext_wr_valid = state_reg.wr_valid;
	assign ext_wr_addr = state_reg.ent0[13:8];
	assign ext_wr_data = state_reg.ent0[7:0];

endmodule

`default_nettype wire

/* File: verif/srpc_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// Pin-level checks on the core; everything lives in the one system clock domain.
module srpc_checker (
	input wire logic mclk, // Clock.
	input wire logic rst_n, // Reset, low.
	input wire logic chip_select_in, // Select pin.
	input wire logic system_voltage_sense, // Supply sense.
	input wire logic miso_oe, // Data out enable.
	input wire logic square_wave_out, // Square wave.
	input wire logic supply_enable_out, // Supply enable.
	input wire logic host_reset_out, // Host reset value.
	input wire logic host_reset_oe, // Host reset enable.
	input wire logic irq_out, // Interrupt value.
	input wire logic irq_oe, // Interrupt enable.
	input wire logic ext_wr_valid, // Buffer head valid.
	input wire logic [5:0] ext_wr_addr, // Buffer head address.
	input wire logic [7:0] ext_wr_data, // Buffer head data.
	input wire logic ext_wr_ready // Buffer head taken.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	// Supply and host reset follow reset, power-down and recovery.
	reset_supply_a: assert property ($rose(rst_n) ##0 system_voltage_sense [*5] |=> supply_enable_out)
		else $error("supply low after reset with sense high");
	pd_entry_a: assert property ($fell(supply_enable_out) |-> ##[0:2] (host_reset_oe && !square_wave_out))
		else $error("power-down left reset or square wave");
	pd_hold_a: assert property ((host_reset_oe && !supply_enable_out) [*3] |-> !square_wave_out)
		else $error("square wave runs in power-down");
	pd_release_a: assert property ($rose(supply_enable_out) |-> ##[0:2] !host_reset_oe)
		else $error("host reset held after supply returned");
	irq_supply_a: assert property ($rose(irq_oe) |-> ##[0:2] supply_enable_out)
		else $error("interrupt did not enable supply");
	irq_hold_a: assert property ($fell(irq_oe) |-> miso_oe)
		else $error("interrupt cleared without status read");
	drain_low_a: assert property (host_reset_out == 1'b0 && irq_out == 1'b0)
		else $error("open-drain value not low");
	// Data out floats once the host has dropped select.
	miso_float_a: assert property (!chip_select_in [*5] |-> !miso_oe)
		else $error("data out driven while deselected");
	miso_fall_a: assert property ($fell(miso_oe) |-> !$past(chip_select_in, 2))
		else $error("data out released while selected");
	buf_hold_a: assert property (ext_wr_valid && !ext_wr_ready |=> ext_wr_valid
		&& $stable(ext_wr_addr) && $stable(ext_wr_data))
		else $error("buffer head changed while stalled");
	cover property ($rose(irq_oe));
	cover property (ext_wr_valid && !ext_wr_ready);
	cover property ($fell(supply_enable_out));
endmodule
bind srpc_core srpc_checker chk (.mclk, .rst_n, .chip_select_in, .system_voltage_sense, .miso_oe,
	.square_wave_out, .supply_enable_out, .host_reset_out, .host_reset_oe, .irq_out, .irq_oe,
	.ext_wr_valid, .ext_wr_addr, .ext_wr_data, .ext_wr_ready);
`default_nettype wire

/* File: verif/srpc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Host master with an idle-low serial clock that stands still between frames.
module srpc_host_model (
	input wire logic mclk, // Clock.
	output logic chip_select_in, // Select.
	output logic sck_in, // Serial clock.
	output logic mosi_in, // Data to the core.
	input wire logic miso_out, // Data from the core.
	input wire logic miso_oe // Core drives data.
);
	// Six cycles a phase leaves margin over the three the port needs.
	localparam int PH = 6;
	initial begin
		chip_select_in = 1'b0;
		sck_in = 1'b0;
		mosi_in = 1'b0;
	end
	// One frame: the address byte always leads, and a new address needs a new select.
	task automatic frame(input logic [7:0] a, input int n, input logic [7:0] wd [4],
		output logic [7:0] rd [4]);
		logic [7:0] b;
		chip_select_in <= 1'b1;
		repeat (PH) @(posedge mclk);
		for (int i = 0; i <= n; i++) begin
			b = (i == 0) ? a : wd[i - 1];
			for (int k = 7; k >= 0; k--) begin
				mosi_in <= b[k];
				repeat (PH) @(posedge mclk);
				sck_in <= 1'b1;
				repeat (PH) @(posedge mclk);
				if (i > 0) rd[i - 1][k] = miso_oe ? miso_out : 1'bx;
				sck_in <= 1'b0;
				// Data must outlast the trailing edge through the synchroniser.
				repeat (PH) @(posedge mclk);
			end
		end
		repeat (PH) @(posedge mclk);
		chip_select_in <= 1'b0;
		mosi_in <= ~mosi_in; // A released line must not keep its last value.
		repeat (12) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

/* File: verif/serial_rtc_power_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Core, host model and a memory stand-in that answers reads with its address and bit 7 set.
module serial_rtc_power_control_tb_top;
	logic mclk, rst_n, xtal_in, line_in, system_voltage_sense, power_fail_in, test_mode_in;
	logic alarm_match_in, minute_tick_in, hour_tick_in, day_tick_in, ext_wr_ready;
	logic chip_select_in, sck_in, mosi_in, miso_out, miso_oe, second_tick_out, square_wave_out;
	logic supply_enable_out, host_reset_out, host_reset_oe, irq_out, irq_oe, battery_mode_out;
	logic ext_wr_valid;
	logic [5:0] ext_rd_addr, ext_wr_addr;
	logic [7:0] ext_rd_data, ext_wr_data, xc;
	logic [13:0] popq [$];
	int err_total, comparisons;
	assign ext_rd_data = {2'h2, ext_rd_addr};
	srpc_core uut (.mclk, .rst_n, .chip_select_in, .sck_in, .mosi_in, .miso_out, .miso_oe,
		.xtal_in, .line_in, .system_voltage_sense, .power_fail_in, .test_mode_in, .alarm_match_in,
		.minute_tick_in, .hour_tick_in, .day_tick_in, .second_tick_out, .square_wave_out,
		.supply_enable_out, .host_reset_out, .host_reset_oe, .irq_out, .irq_oe, .battery_mode_out,
		.ext_rd_addr, .ext_rd_data, .ext_wr_valid, .ext_wr_addr, .ext_wr_data, .ext_wr_ready);
	srpc_host_model host (.mclk, .chip_select_in, .sck_in, .mosi_in, .miso_out, .miso_oe);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Crystal at an eighth of the clock rate keeps it well inside the synchroniser's reach.
	always @(posedge mclk) begin
		xc <= xc + 8'h01;
		xtal_in <= xc[2];
		line_in <= xc[7];
		if (ext_wr_valid === 1'b1 && ext_wr_ready === 1'b1) popq.push_back({ext_wr_addr, ext_wr_data});
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string what, input logic [13:0] exp, input logic [13:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input int n, input logic [7:0] d0, input logic [7:0] d1);
		logic [7:0] q [4];
		host.frame({2'h2, a}, n, '{d0, d1, 8'h00, 8'h00}, q);
	endtask
	task automatic rd(input logic [5:0] a, input int n, input logic [7:0] e0, input logic [7:0] e1);
		logic [7:0] q [4];
		host.frame({2'h0, a}, n, '{default: 8'h00}, q);
		cmp("read byte 0", 14'(e0), 14'(q[0]));
		if (n > 1) cmp("read byte 1", 14'(e1), 14'(q[1]));
	endtask
	// Bounded wait on irq_oe (0), supply_enable_out (1) or host_reset_oe (2).
	task automatic poll(input int s, input logic want, input string what);
		logic v;
		for (int i = 0; i < 400; i++) begin
			@(posedge mclk);
			v = (s == 0) ? irq_oe : (s == 1) ? supply_enable_out : host_reset_oe;
			if (v === want) begin
				cmp(what, 14'(want), 14'(v));
				return;
			end
		end
		cmp(what, 14'(want), 14'(v));
		conclude();
	endtask
	// Records whether the square wave was seen high and seen low.
	task automatic sq(input logic [1:0] e, input string w);
		logic [1:0] seen;
		seen = 2'h0;
		repeat (24) begin
			@(posedge mclk);
			seen |= {square_wave_out === 1'b1, square_wave_out === 1'b0};
		end
		cmp(w, 14'(e), 14'(seen));
	endtask
	task automatic pulse(input int s);
		@(posedge mclk);
		{day_tick_in, hour_tick_in, minute_tick_in, alarm_match_in} <= 4'h1 << s;
		@(posedge mclk);
		{day_tick_in, hour_tick_in, minute_tick_in, alarm_match_in} <= 4'h0;
	endtask
	initial begin
		repeat (100000) @(posedge mclk);
		cmp("run length", 14'h0, 14'h1);
		conclude();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, xtal_in, line_in, power_fail_in, test_mode_in, alarm_match_in} = 6'h00;
		{minute_tick_in, hour_tick_in, day_tick_in, xc} = 11'h000;
		{system_voltage_sense, ext_wr_ready} = 2'h3;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		cmp("supply after reset", 14'h1, 14'(supply_enable_out));
		sq(2'h3, "square wave after reset");
		rd(6'h30, 1, 8'h10, 8'h00);
		rd(6'h30, 1, 8'h00, 8'h00);
		rd(6'h31, 2, 8'h00, 8'h00);
		wr(6'h30, 1, 8'hFF, 8'h00);
		rd(6'h30, 1, 8'h00, 8'h00);
		wr(6'h31, 1, 8'h04, 8'h00);
		sq(2'h1, "square wave held low");
		rd(6'h31, 1, 8'h04, 8'h00);
		rd(6'h3F, 2, 8'hBF, 8'hA0);
		rd(6'h1F, 2, 8'h9F, 8'h80);
		$display("end of registers and address test");
		popq.delete();
		ext_wr_ready <= 1'b0;
		wr(6'h05, 2, 8'h5A, 8'hA5);
		cmp("stalled head", {1'b1, 6'h05, 7'h00}, {ext_wr_valid, ext_wr_addr, 7'h00});
		cmp("stalled data", 14'h5A, 14'(ext_wr_data));
		ext_wr_ready <= 1'b1;
		repeat (6) @(posedge mclk);
		cmp("first pop", {6'h05, 8'h5A}, popq[0]);
		cmp("second pop", {6'h06, 8'hA5}, popq[1]);
		$display("end of write buffer test");
		for (int r = 13; r <= 15; r++) begin
			wr(6'h32, 1, 8'(r), 8'h00);
			pulse(r - 12);
			poll(0, 1'b1, "periodic irq");
			rd(6'h30, 1, 8'h09, 8'h00);
			poll(0, 1'b0, "irq after read");
		end
		wr(6'h32, 1, 8'h00, 8'h00);
		pulse(0);
		repeat (6) @(posedge mclk);
		cmp("gated alarm", 14'h0, 14'(irq_oe));
		wr(6'h32, 1, 8'h10, 8'h00);
		pulse(0);
		poll(0, 1'b1, "alarm irq");
		rd(6'h30, 1, 8'h0A, 8'h00);
		$display("end of interrupt test");
		wr(6'h31, 1, 8'h00, 8'h00);
		wr(6'h32, 1, 8'h50, 8'h00);
		poll(1, 1'b0, "supply off");
		cmp("host reset in power-down", 14'h1, 14'(host_reset_oe));
		sq(2'h1, "square wave in power-down");
		wr(6'h31, 1, 8'h07, 8'h00);
		pulse(0);
		poll(1, 1'b1, "supply after irq");
		poll(2, 1'b0, "host reset after irq");
		rd(6'h30, 1, 8'h0A, 8'h00);
		rd(6'h31, 1, 8'h00, 8'h00);
		wr(6'h32, 1, 8'h40, 8'h00);
		poll(1, 1'b0, "supply off again");
		system_voltage_sense <= 1'b0;
		repeat (10) @(posedge mclk);
		system_voltage_sense <= 1'b1;
		poll(1, 1'b1, "supply on recovery");
		poll(2, 1'b0, "host reset on recovery");
		sq(2'h3, "square wave on recovery");
		$display("end of power-down test");
		wr(6'h32, 1, 8'h20, 8'h00);
		power_fail_in <= 1'b1;
		poll(0, 1'b1, "sense irq");
		rd(6'h30, 1, 8'h0C, 8'h00);
		poll(0, 1'b0, "sense irq read");
		power_fail_in <= 1'b0;
		test_mode_in <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(6'h30, 1, 8'h2C, 8'h00);
		wr(6'h32, 1, 8'h00, 8'h00);
		wr(6'h32, 1, 8'h20, 8'h00);
		rd(6'h32, 1, 8'h20, 8'h00);
		$display("end of power sense test");
		conclude();
	end
endmodule
`default_nettype wire
